/* hdl/ibs_pkg.sv */
// Package of constants and types for the bus status flag block.
package ibs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // The printed offset is not a multiple of four, so every offset here is a word index.
  // The byte address on the register bus is four times the index.
  localparam logic [15:0] BUS_STATUS_0_OFFS = 16'hFFAA;
  localparam logic [15:0] CTRL_OFFS = 16'hFF80;
  localparam logic [15:0] EVENT_OFFS = 16'hFF84;
  localparam logic [15:0] IRQ_STATUS_OFFS = 16'hFF88;
  localparam logic [15:0] IRQ_MASK_OFFS = 16'hFF8C;
  localparam logic [15:0] OWN_ADDR_OFFS = 16'hFF90;
  localparam logic [15:0] BIT_ACCESS_OFFS = 16'hFF94;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int MASTER_BIT = 7;
  localparam int ARB_BIT = 6;
  localparam int EXT_BIT = 5;
  localparam int MATCH_BIT = 4;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [3:0] EXT_CODE_LOW = 4'h0;
  localparam logic [3:0] EXT_CODE_HIGH = 4'hF;
  localparam logic [6:0] OWN_ADDR_RESET = 7'h00;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Bus events from the serial engine
  // ----------------------------------------------------------------
  typedef struct packed {
    logic start_gen;
    logic start_det;
    logic stop_det;
    logic arb_lost;
    logic addr_byte_done;
    logic [7:0] addr_byte;
  } ibs_bus_event_type;

endpackage

/* hdl/ibs_status_flags.sv */
// Status flags of the upper status register half, with an AXI4-Lite slave.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Notes on behaviour
// (RULE1) Status byte at FFAA: bits 7..4 master, arbitration, extension, match.
// (RULE2) Reset clears the whole status byte to zero.
// (RULE3) Software reads only by bit or byte, with trigger set and in wait.
// (RULE4) Software must not read while address wakeup is enabled in stop.
// (RULE5) After wakeup enable falls, flags freeze until next start or stop.
// (RULE6) With wakeup, software enables stop interrupt and reads after it.
// (RULE7) Master flag sets on generated start; clears on stop, loss, exit, disable.
// (RULE8) Arbitration loss sets its flag and clears master flag together.
// (RULE9) Arbitration flag clears after status read, on disable, on reset.
// (RULE10) A bit access to any other status bit clears arbitration flag.
// (RULE11) Software reads arbitration flag before touching other status bits.
// (RULE12) Extension flag sets at eighth clock when address nibble is 0000 or 1111.
// (RULE13) Extension flag clears on start, stop, exit, disable, reset.
// (RULE14) Match flag sets at eighth clock on own address; clears like extension.
// (RULE15) All flags stay zero while the unit is disabled.
// ----------------------------------------------------------------
module ibs_status_flags (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire ibs_pkg::ibs_bus_event_type bus_event,
  input wire logic start_trigger,
  input wire logic in_wait,
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic bus_irq
);
  import ibs_pkg::*;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic unit_enable_q;
  logic addr_wakeup_enable_q;
  logic stop_irq_enable_q;
  logic [6:0] own_slave_address_q;
  logic [3:0] irq_status_q;
  logic [3:0] irq_mask_q;
  logic master_active_flag_q;
  logic arb_lost_flag_q;
  logic ext_code_flag_q;
  logic addr_match_flag_q;
  logic freeze_q;
  logic unit_enable_d;
  logic wakeup_d;
  logic comm_exit;
  logic enable_fall;
  logic [3:0] flag_set;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_held_q;
  logic w_held_q;
  logic [15:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic rd_fire;
  logic status_read;
  logic bit_access;
  logic [7:0] status_byte;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Every register is one aligned word, so the two low byte-address bits are dropped.
  // What remains is the word index that the offsets name.
  logic [15:0] ar_index;
  assign ar_index = s_axi_araddr[17:2];

  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign status_byte = {master_active_flag_q, arb_lost_flag_q, ext_code_flag_q,
                        addr_match_flag_q, 4'h0}; // RULE1

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 16'h0000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      // The readies pulse on alternate idle cycles.
      // A master must hold its valid until it sees one high.
      s_axi_awready <= !aw_held_q && !s_axi_awready;
      s_axi_wready <= !w_held_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        // The write address is kept as a word index as well.
        awaddr_q <= s_axi_awaddr[17:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awaddr_q)
          CTRL_OFFS, IRQ_STATUS_OFFS, IRQ_MASK_OFFS, OWN_ADDR_OFFS, BIT_ACCESS_OFFS:
            s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control writes; only byte lane 0 carries bits.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      unit_enable_q <= 1'b0;
      addr_wakeup_enable_q <= 1'b0;
      stop_irq_enable_q <= 1'b0;
      own_slave_address_q <= OWN_ADDR_RESET;
      irq_mask_q <= IRQ_RESET;
    end else if (wr_fire && wstrb_q[0]) begin
      case (awaddr_q)
        CTRL_OFFS: begin
          unit_enable_q <= wdata_q[0];
          addr_wakeup_enable_q <= wdata_q[1];
          stop_irq_enable_q <= wdata_q[2];
        end
        IRQ_MASK_OFFS: irq_mask_q <= wdata_q[3:0];
        OWN_ADDR_OFFS: own_slave_address_q <= wdata_q[6:0];
        default: ;
      endcase
    end
  end

  // Leaving communication is a write pulse, not stored state.
  assign comm_exit = wr_fire && wstrb_q[0] && (awaddr_q == CTRL_OFFS) && wdata_q[3];

  // A single-bit access names a bit of the status byte through a write to this offset; no bit value comes back.
  // Only the low three data bits name the bit; the other bits are ignored.
  assign bit_access = wr_fire && wstrb_q[0] && (awaddr_q == BIT_ACCESS_OFFS);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (ar_index)
          BUS_STATUS_0_OFFS: s_axi_rdata <= {24'h000000, status_byte};
          CTRL_OFFS: s_axi_rdata <= {28'h0000000, 1'b0, stop_irq_enable_q,
                                     addr_wakeup_enable_q, unit_enable_q};
          EVENT_OFFS: s_axi_rdata <= {30'h0, start_trigger, in_wait};
          IRQ_STATUS_OFFS: s_axi_rdata <= {28'h0000000, irq_status_q};
          IRQ_MASK_OFFS: s_axi_rdata <= {28'h0000000, irq_mask_q};
          OWN_ADDR_OFFS: s_axi_rdata <= {25'h0, own_slave_address_q};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // The read clears on the take, so the data word still shows the flag as it stood.
  assign status_read = rd_fire && (ar_index == BUS_STATUS_0_OFFS);

  // ----------------------------------------------------------------
  // Flag logic
  // ----------------------------------------------------------------
  // The wakeup enable is compared with its value one cycle earlier, so the freeze
  // starts one cycle after the fall; a set in that very cycle still lands.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      unit_enable_d <= 1'b0;
      wakeup_d <= 1'b0;
      freeze_q <= 1'b0;
    end else begin
      unit_enable_d <= unit_enable_q;
      wakeup_d <= addr_wakeup_enable_q;
      if (bus_event.start_det || bus_event.stop_det || !unit_enable_q) begin
        freeze_q <= 1'b0; // RULE5
      end else if (wakeup_d && !addr_wakeup_enable_q) begin
        freeze_q <= 1'b1; // RULE5
      end
    end
  end

  // The fall is also covered by the disabled level; the edge term keeps the intent visible.
  assign enable_fall = unit_enable_d && !unit_enable_q;

  // Master flag: loss wins over a start in the same cycle.
  always_ff @(posedge core_clk) begin
    if (sys_rst || !unit_enable_q || enable_fall) begin
      master_active_flag_q <= 1'b0; // RULE7 RULE15
    end else if (bus_event.stop_det || bus_event.arb_lost || comm_exit) begin
      master_active_flag_q <= 1'b0; // RULE7 RULE8
    end else if (bus_event.start_gen && !freeze_q) begin
      master_active_flag_q <= 1'b1; // RULE7
    end
  end

  // A loss in the same cycle as the clearing read is kept.
  always_ff @(posedge core_clk) begin
    if (sys_rst || !unit_enable_q || enable_fall) begin
      arb_lost_flag_q <= 1'b0; // RULE2 RULE9 RULE15
    end else if (bus_event.arb_lost && !freeze_q) begin
      arb_lost_flag_q <= 1'b1; // RULE8
    end else if (status_read) begin
      arb_lost_flag_q <= 1'b0; // RULE9
    end else if (bit_access && wdata_q[2:0] != 3'(ARB_BIT)) begin
      arb_lost_flag_q <= 1'b0; // RULE10
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || !unit_enable_q || enable_fall) begin
      ext_code_flag_q <= 1'b0; // RULE13 RULE15
    end else if (bus_event.start_det || bus_event.stop_det || comm_exit) begin
      ext_code_flag_q <= 1'b0; // RULE13
    end else if (bus_event.addr_byte_done && !freeze_q &&
                 (bus_event.addr_byte[7:4] == EXT_CODE_LOW ||
                  bus_event.addr_byte[7:4] == EXT_CODE_HIGH)) begin
      ext_code_flag_q <= 1'b1; // RULE12
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || !unit_enable_q || enable_fall) begin
      addr_match_flag_q <= 1'b0; // RULE14 RULE15
    end else if (bus_event.start_det || bus_event.stop_det || comm_exit) begin
      addr_match_flag_q <= 1'b0; // RULE14
    end else if (bus_event.addr_byte_done && !freeze_q &&
                 bus_event.addr_byte[7:1] == own_slave_address_q) begin
      addr_match_flag_q <= 1'b1; // RULE14
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Events: bit 0 stop (gated by its enable), 1 loss, 2 extension, 3 match.
  assign flag_set = {bus_event.addr_byte_done && !freeze_q &&
                     bus_event.addr_byte[7:1] == own_slave_address_q,
                     bus_event.addr_byte_done && !freeze_q &&
                     (bus_event.addr_byte[7:4] == EXT_CODE_LOW ||
                      bus_event.addr_byte[7:4] == EXT_CODE_HIGH),
                     bus_event.arb_lost && !freeze_q,
                     bus_event.stop_det && stop_irq_enable_q} & {4{unit_enable_q}};

  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_status_q <= IRQ_RESET;
    end else if (wr_fire && wstrb_q[0] && awaddr_q == IRQ_STATUS_OFFS) begin
      irq_status_q <= (irq_status_q & ~wdata_q[3:0]) | flag_set;
    end else begin
      irq_status_q <= irq_status_q | flag_set;
    end
  end

  // The request lags the status bit by one cycle so that the pin comes from a flip-flop.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bus_irq <= 1'b0;
    end else begin
      bus_irq <= |(irq_status_q & irq_mask_q);
    end
  end

endmodule // ibs_status_flags

/* testbench/ibs_bus_model.sv */
// Behavioural model of the other stations on the serial bus.
`timescale 1ns/1ps
module ibs_bus_model (
  input wire logic core_clk,
  input wire logic [2:0] ev_op,
  input wire logic [7:0] ev_addr,
  output ibs_pkg::ibs_bus_event_type bus_event
);
  import ibs_pkg::*;
  // ------------
  // Event pulses
  // ------------
  // The address lane is only valid with its strobe, so it shows the inverse otherwise.
  always @(posedge core_clk) begin
    bus_event.start_gen <= ev_op == 3'h1;
    bus_event.start_det <= ev_op == 3'h2;
    bus_event.stop_det <= ev_op == 3'h3;
    bus_event.arb_lost <= ev_op == 3'h4;
    bus_event.addr_byte_done <= ev_op == 3'h5;
    bus_event.addr_byte <= (ev_op == 3'h5) ? ev_addr : ~ev_addr;
  end
endmodule // ibs_bus_model

/* testbench/ibs_status_flags_assertions.sv */
// Concurrent checks on the ports of the status flag block.
`timescale 1ns/1ps
module ibs_status_flags_assertions (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire ibs_pkg::ibs_bus_event_type bus_event,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic bus_irq
);
  import ibs_pkg::*;
  // ------------
  // Helper state
  // ------------
  // A clean bit only proves a flag is zero; any doubtful event drops it.
  logic arb_ok_q;
  logic adr_ok_q;
  logic mst_ok_q;
  logic ar_hit;
  logic ar_map;
  assign ar_hit = s_axi_arvalid && s_axi_arready;
  assign ar_map = s_axi_araddr[17:2] inside {BUS_STATUS_0_OFFS, CTRL_OFFS, EVENT_OFFS,
    IRQ_STATUS_OFFS, IRQ_MASK_OFFS, OWN_ADDR_OFFS, BIT_ACCESS_OFFS};
  always_ff @(posedge core_clk) begin
    if (sys_rst || bus_event.arb_lost) arb_ok_q <= !bus_event.arb_lost;
    else if (ar_hit && s_axi_araddr[17:2] == BUS_STATUS_0_OFFS) arb_ok_q <= 1'h1;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst || bus_event.addr_byte_done) adr_ok_q <= !bus_event.addr_byte_done;
    else if (bus_event.start_det || bus_event.stop_det) adr_ok_q <= 1'h1;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst || bus_event.start_gen) mst_ok_q <= !bus_event.start_gen;
    else if (bus_event.stop_det || bus_event.arb_lost) mst_ok_q <= 1'h1;
  end
  // ----------
  // Properties
  // ----------
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence stat_req;
    ar_hit && s_axi_araddr[17:2] == BUS_STATUS_0_OFFS;
  endsequence
  rst_clear_a: assert property (disable iff (1'h0)
    sys_rst |=> !s_axi_rvalid && !s_axi_bvalid && !bus_irq) else $error("Not idle after reset.");
  stat_frame_a: assert property (stat_req |=>
    s_axi_rvalid && s_axi_rresp == RESP_OKAY && s_axi_rdata[3:0] == 4'h0) else $error("Bad read.");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("Upper read bits set.");
  unmapped_a: assert property (ar_hit && !ar_map |=>
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("No error.");
  no_both_a: assert property (stat_req ##1 s_axi_rvalid |->
    !(s_axi_rdata[MASTER_BIT] && s_axi_rdata[ARB_BIT])) else $error("Master and loss both set.");
  arb_clear_a: assert property (stat_req ##0 arb_ok_q |=> !s_axi_rdata[ARB_BIT])
    else $error("Loss flag not cleared.");
  adr_clear_a: assert property (stat_req ##0 adr_ok_q |=>
    s_axi_rdata[EXT_BIT:MATCH_BIT] == 2'h0) else $error("Address flags not cleared.");
  mst_clear_a: assert property (stat_req ##0 mst_ok_q |=> !s_axi_rdata[MASTER_BIT])
    else $error("Master flag not cleared.");
endmodule // ibs_status_flags_assertions
bind ibs_status_flags ibs_status_flags_assertions chk_i (.core_clk, .sys_rst, .bus_event,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_bvalid, .bus_irq);

/* testbench/tb_ibs_status_flags.sv */
// Self-checking bench for the bus status flag block.
`timescale 1ns/1ps
module tb_ibs_status_flags;
  import ibs_pkg::*;
  logic core_clk = 1'h0, sys_rst = 1'h1, start_trigger = 1'h0, in_wait = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_irq;
  logic [17:0] s_axi_awaddr = 18'h00000, s_axi_araddr = 18'h00000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] ev_op = 3'h0;
  logic [7:0] ev_addr = 8'h00;
  logic [7:0] ext_addr [5] = '{8'h05, 8'hF1, 8'h10, 8'hE0, 8'h0E};
  logic [4:0] ext_hit = 5'h13;
  ibs_bus_event_type bus_event;
  int n_mismatch = 0, samples_checked = 0, cyc = 0;
  always #50 core_clk = ~core_clk;
  ibs_status_flags uut (.core_clk, .sys_rst, .bus_event, .start_trigger, .in_wait,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_irq);
  ibs_bus_model far_side (.core_clk, .ev_op, .ev_addr, .bus_event);
  // -----
  // Tasks
  // -----
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d.", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  // The write waits one spare edge after both takes; the answer may already stand then.
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    @(posedge core_clk);
    s_axi_awaddr <= {a, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (s_axi_bvalid !== 1'h1) @(posedge core_clk);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task automatic rc(input logic [15:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
    @(posedge core_clk);
    s_axi_araddr <= {a, 2'b00};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge core_clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask
  task automatic st(input logic [31:0] e);
    rc(BUS_STATUS_0_OFFS, e);
  endtask
  task automatic ev(input logic [2:0] o, input logic [7:0] a);
    @(posedge core_clk);
    ev_op <= o;
    ev_addr <= a;
    @(posedge core_clk);
    ev_op <= 3'h0;
  endtask
  // --------
  // Sequence
  // --------
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'h0;
    rc(EVENT_OFFS, 32'h0);
    start_trigger <= 1'h1;
    in_wait <= 1'h1;
    st(32'h0);
    wr(BUS_STATUS_0_OFFS, 32'h0, RESP_SLVERR);
    rc(CTRL_OFFS, 32'h0);
    rc(16'h0000, 32'h0, RESP_SLVERR);
    ev(3'h1, 8'h00);
    st(32'h0);
    wr(CTRL_OFFS, 32'h1);
    ev(3'h1, 8'h00);
    st(32'h80);
    ev(3'h3, 8'h00);
    st(32'h0);
    ev(3'h1, 8'h00);
    ev(3'h4, 8'h00);
    st(32'h40);
    st(32'h0);
    ev(3'h4, 8'h00);
    wr(BIT_ACCESS_OFFS, 32'h7);
    st(32'h0);
    ev(3'h4, 8'h00);
    wr(BIT_ACCESS_OFFS, 32'h6);
    st(32'h40);
    ev(3'h1, 8'h00);
    wr(CTRL_OFFS, 32'h9);
    st(32'h0);
    for (int i = 0; i < 5; i++) begin
      ev(3'h5, ext_addr[i]);
      st({26'h0, ext_hit[i], 5'h0});
      ev(i[0] ? 3'h3 : 3'h2, 8'h00);
      st(32'h0);
    end
    wr(OWN_ADDR_OFFS, 32'h3A);
    ev(3'h5, 8'h75);
    st(32'h10);
    wr(CTRL_OFFS, 32'h9);
    st(32'h0);
    wr(IRQ_STATUS_OFFS, 32'hF);
    wr(CTRL_OFFS, 32'h7);
    wr(CTRL_OFFS, 32'h5);
    ev(3'h5, 8'h05);
    st(32'h0);
    ev(3'h3, 8'h00);
    rc(IRQ_STATUS_OFFS, 32'h1);
    ev(3'h5, 8'h05);
    st(32'h20);
    ev(3'h1, 8'h00);
    ev(3'h5, 8'h75);
    ev(3'h4, 8'h00);
    wr(CTRL_OFFS, 32'h0);
    st(32'h0);
    ev(3'h1, 8'h00);
    st(32'h0);
    wr(CTRL_OFFS, 32'h1);
    wr(IRQ_STATUS_OFFS, 32'hF);
    wr(IRQ_MASK_OFFS, 32'h0);
    ev(3'h4, 8'h00);
    rc(IRQ_STATUS_OFFS, 32'h2);
    chk({31'h0, bus_irq}, 32'h0);
    wr(IRQ_MASK_OFFS, 32'h2);
    repeat (3) @(posedge core_clk);
    chk({31'h0, bus_irq}, 32'h1);
    wr(IRQ_STATUS_OFFS, 32'h2);
    rc(IRQ_STATUS_OFFS, 32'h0);
    chk({31'h0, bus_irq}, 32'h0);
    s_axi_wstrb <= 4'h0;
    wr(CTRL_OFFS, 32'h0);
    s_axi_wstrb <= 4'hF;
    rc(CTRL_OFFS, 32'h1);
    rc(EVENT_OFFS, 32'h3);
    st(32'h40);
    tally_and_finish();
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
endmodule // tb_ibs_status_flags
